// ===== inc/conversion_clock_divider_pkg.sv
// constants, register map and types of the converter sequencer
package conversion_clock_divider_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTL_ONE   = 8'h00;
    localparam logic [7:0] OFS_CTL_TWO   = 8'h04;
    localparam logic [7:0] OFS_CTL_THREE = 8'h08;
    localparam logic [7:0] OFS_IN_SEL    = 8'h0C;
    localparam logic [7:0] OFS_SCAN_LO   = 8'h10;
    localparam logic [7:0] OFS_SCAN_HI   = 8'h14;

    // writable bits of each register
    localparam logic [31:0] MASK_CTL_ONE   = 32'h0000_80E6;
    localparam logic [31:0] MASK_CTL_TWO   = 32'h0000_F43F;
    localparam logic [31:0] MASK_CTL_THREE = 32'h0000_9FFF;
    localparam logic [31:0] MASK_IN_SEL    = 32'hBFBF_0000;
    localparam logic [31:0] MASK_SCAN_LO   = 32'hFFFF_FFFF;
    localparam logic [31:0] MASK_SCAN_HI   = 32'h0007_FFFF;
    localparam logic [31:0] RESET_VALUE    = 32'h0000_0000;

    // control one fields
    localparam int B_ON      = 15;
    localparam int B_TRIG_LO = 5;
    localparam int B_ASTART  = 2;
    localparam int B_SAMPLE  = 1;
    localparam int B_DONE    = 0;
    // control two fields
    localparam int B_OFFSET_CALIBRATION_ENABLE  = 12;
    localparam int B_SCAN    = 10;
    localparam int B_HALF    = 7;
    localparam int B_SEQ_LO  = 2;
    localparam int B_SPLIT   = 1;
    localparam int B_ALT     = 0;
    // control three fields
    localparam int B_CLKSRC  = 15;
    localparam int B_SAMT_LO = 8;
    localparam int B_DIV_LO  = 0;
    // input select fields
    localparam int B_NEG_B   = 31;
    localparam int B_POS_B   = 24;
    localparam int B_NEG_A   = 23;
    localparam int B_POS_A   = 16;

    localparam logic [2:0] TRIG_SOFT = 3'b000;
    localparam logic [2:0] TRIG_AUTO = 3'b111;

    // highest existing positive input code per package
    localparam logic [5:0] MAX_CODE_64  = 6'h1E;
    localparam logic [5:0] MAX_CODE_100 = 6'h32;
    localparam logic [5:0] SLOT_NONE    = 6'h3F;

    // conversion length in conversion clock periods
    localparam logic [4:0] CONV_TADS = 5'h0C;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} conversion_clock_divider_state_t;

endpackage

// ===== core/conversion_clock_divider_tad_div.sv
// conversion clock divider: one tick every 2*(div+1) cycles
`timescale 1ns/1ps
module conversion_clock_divider_tad_div
    import conversion_clock_divider_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         ref_clk, // system clock
    input  wire logic         rst_n,   // synchronous reset
    input  wire logic         ce,      // clock enable
    input  wire logic         run,     // counter active
    input  wire logic [W-1:0] div,     // divider field
    output logic              tick     // one-cycle period tick
);
    typedef struct packed {
        logic [W:0] cnt;
        logic       tick;
    } conversion_clock_divider_div_st_t;

    conversion_clock_divider_div_st_t s_reg;
    conversion_clock_divider_div_st_t s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.tick = 1'b0;
        if (!run) begin
            s_next.cnt = '0;
        end else if (s_reg.cnt >= {div, 1'b1}) begin
            s_next.cnt  = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;
endmodule // conversion_clock_divider_tad_div

// ===== core/conversion_clock_divider_sequencer.sv
// sample/convert sequencer with configuration registers on apb
//
// How it works
// - offset calibration ties both inputs low reference
// - scan enable steps masked inputs, else select
// - half status reads active half in split
// - event after every N+1 sequences
// - split mode: two 8-word halves, else 16
// - alternate mode uses A, B, A, B
// - clock source bit picks fast rc
// - sample time used only with auto trigger
// - bus clock period times 2(div+1)
// - divider ignored when fast rc chosen
// - negative select: input 1 or low reference
// - 64-pin positive codes, 28-30 special inputs
// - 100-pin positive codes, 48-50 special inputs
// - low mask bit x scans input x
// - 64-pin slots 28-30 are internal sources
// - missing inputs convert the low reference
// - high mask inputs 32-50, 100-pin only
// - unimplemented bits read zero, ignore writes
// - auto trigger ends sampling after sample time
// - done set on completion, cleared when the next conversion begins
`timescale 1ns/1ps
module conversion_clock_divider_sequencer
    import conversion_clock_divider_pkg::*;
#(
    parameter bit PINS_100 = 1'b1 // 1: 100-pin part, 0: 64-pin part
) (
    input  wire logic        ref_clk,      // system clock
    input  wire logic        rst_n,        // synchronous reset, active low
    input  wire logic        ce,           // clock enable
    input  wire logic        psel,         // apb select
    input  wire logic        penable,      // apb enable
    input  wire logic        pwrite,       // apb write
    input  wire logic [7:0]  paddr,        // apb byte address
    input  wire logic [31:0] pwdata,       // apb write data
    output logic [31:0]      prdata,       // apb read data
    output logic             pready,       // apb ready
    output logic             pslverr,      // apb error, unmapped
    input  wire logic        frcClk,       // fast rc oscillator pin
    input  wire logic        trigIn,       // external trigger pin
    input  wire logic [9:0]  sarData,      // converter result pins
    output logic [5:0]       muxPos,       // positive input code
    output logic             muxPosLowRef, // positive to low reference
    output logic             muxNegAn1,    // negative to input 1
    output logic             sampling,     // sample-and-hold tracking
    output logic             converting,   // conversion running
    output logic             resultValid,  // result write strobe
    output logic [3:0]       resultIndex,  // result buffer word
    output logic [9:0]       resultData,   // result value
    output logic             seqEvent      // converter interrupt event
);
    typedef struct packed {
        logic [31:0] ctlOne;
        logic [31:0] ctlTwo;
        logic [31:0] ctlThree;
        logic [31:0] inSel;
        logic [31:0] scanLo;
        logic [31:0] scanHi;
        logic [31:0] rdata;
        conversion_clock_divider_state_t st;
        logic [4:0]  cnt;
        logic [5:0]  slot;
        logic        altB;
        logic [3:0]  seqCnt;
        logic [3:0]  offs;
        logic        half;
        logic        done;
        logic [1:0]  trigSync;
        logic        trigLast;
        logic [1:0]  frcSync;
        logic        frcLast;
        logic [9:0]  sarMeta;
        logic [9:0]  sarSync;
        logic        resValid;
        logic [3:0]  resIdx;
        logic [9:0]  resData;
        logic        evt;
    } conversion_clock_divider_st_t;

    conversion_clock_divider_st_t s_reg;
    conversion_clock_divider_st_t s_next;

    logic        divTick;
    logic        tadTick;
    logic        useFrc;
    logic        frcEdge;
    logic        trigEdge;
    logic [50:0] scanMask;
    logic [5:0]  posCode;
    logic [5:0]  maxCode;
    logic [2:0]  trigSrc;
    logic        wrEn;
    logic        rdSetup;
    logic        addrHit;

    ////////////////////////////////////////////////////////////////////////////////
    // conversion clock

    // rc pin crosses domains: edge logic reads only the second sync stage
    assign useFrc  = s_reg.ctlThree[B_CLKSRC];
    assign frcEdge = s_reg.frcSync[1] & ~s_reg.frcLast;
    assign tadTick = useFrc ? frcEdge : divTick;

    conversion_clock_divider_tad_div #(
        .W (8)
    ) u_div (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .run     (~useFrc),
        .div     (s_reg.ctlThree[B_DIV_LO +: 8]),
        .tick    (divTick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // input selection

    // high mask exists only on the larger package
    assign scanMask = PINS_100 ? {s_reg.scanHi[18:0], s_reg.scanLo}
                               : {19'h0, s_reg.scanLo};
    assign maxCode  = PINS_100 ? MAX_CODE_100 : MAX_CODE_64;
    assign trigSrc  = s_reg.ctlOne[B_TRIG_LO +: 3];

    always_comb begin
        if (s_reg.ctlTwo[B_SCAN]) begin
            posCode = s_reg.slot;
        end else if (s_reg.altB) begin
            posCode = s_reg.inSel[B_POS_B +: 6];
        end else begin
            posCode = s_reg.inSel[B_POS_A +: 6];
        end
    end

    assign muxPos       = posCode;
    assign muxPosLowRef = s_reg.ctlTwo[B_OFFSET_CALIBRATION_ENABLE] | (posCode > maxCode);
    assign muxNegAn1    = ~s_reg.ctlTwo[B_OFFSET_CALIBRATION_ENABLE]
                        & (s_reg.altB ? s_reg.inSel[B_NEG_B]
                                      : s_reg.inSel[B_NEG_A]);

    // next selected slot above cur, wrapping to the lowest
    function automatic logic [5:0] next_slot(input logic [50:0] m, input logic [5:0] cur);
        logic [5:0] above;
        logic [5:0] low;
        logic       fa;
        logic       fl;
        above = cur;
        low   = cur;
        fa    = 1'b0;
        fl    = 1'b0;
        for (int i = 50; i >= 0; i--) begin
            if (m[i]) begin
                low = 6'(i);
                fl  = 1'b1;
                if (6'(i) > cur) begin
                    above = 6'(i);
                    fa    = 1'b1;
                end
            end
        end
        // an empty mask keeps slot none, which converts the low reference
        next_slot = fa ? above : (fl ? low : cur);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    // zero wait states: pready follows the access phase directly
    assign wrEn    = psel & penable & pwrite;
    assign rdSetup = psel & ~penable;
    assign addrHit = (paddr == OFS_CTL_ONE) || (paddr == OFS_CTL_TWO)
                  || (paddr == OFS_CTL_THREE) || (paddr == OFS_IN_SEL)
                  || (paddr == OFS_SCAN_LO) || (paddr == OFS_SCAN_HI);
    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~addrHit;
    assign prdata  = s_reg.rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic wrOne;
        logic convEnd;
        logic toConvert;
        logic [3:0] base;
        wrOne     = wrEn && (paddr == OFS_CTL_ONE);
        convEnd   = 1'b0;
        toConvert = 1'b0;
        base      = 4'h0;
        s_next    = s_reg;

        s_next.trigSync = {s_reg.trigSync[0], trigIn};
        s_next.trigLast = s_reg.trigSync[1];
        s_next.frcSync  = {s_reg.frcSync[0], frcClk};
        s_next.frcLast  = s_reg.frcSync[1];
        s_next.sarMeta  = sarData;
        s_next.sarSync  = s_reg.sarMeta;
        s_next.resValid = 1'b0;
        s_next.evt      = 1'b0;

        // read data latched in the setup cycle
        if (rdSetup) begin
            unique case (paddr)
                OFS_CTL_ONE: begin
                    // sample and done bits reflect state, never the stored write
                    s_next.rdata = {s_reg.ctlOne[31:2] & MASK_CTL_ONE[31:2],
                                    s_reg.st == ST_SAMPLE,
                                    s_reg.done};
                end
                OFS_CTL_TWO: begin
                    s_next.rdata = (s_reg.ctlTwo & MASK_CTL_TWO)
                                 | {24'h0, s_reg.half, 7'h0};
                end
                OFS_CTL_THREE: s_next.rdata = s_reg.ctlThree & MASK_CTL_THREE;
                OFS_IN_SEL:    s_next.rdata = s_reg.inSel & MASK_IN_SEL;
                OFS_SCAN_LO:   s_next.rdata = s_reg.scanLo & MASK_SCAN_LO;
                OFS_SCAN_HI:   s_next.rdata = s_reg.scanHi & MASK_SCAN_HI;
                default:       s_next.rdata = RESET_VALUE;
            endcase
        end

        if (wrEn) begin
            unique case (paddr)
                OFS_CTL_ONE:   s_next.ctlOne   = pwdata & MASK_CTL_ONE;
                OFS_CTL_TWO:   s_next.ctlTwo   = pwdata & MASK_CTL_TWO;
                OFS_CTL_THREE: s_next.ctlThree = pwdata & MASK_CTL_THREE;
                OFS_IN_SEL:    s_next.inSel    = pwdata & MASK_IN_SEL;
                OFS_SCAN_LO:   s_next.scanLo   = pwdata & MASK_SCAN_LO;
                OFS_SCAN_HI:   s_next.scanHi   = pwdata & MASK_SCAN_HI;
                default:       s_next.rdata    = s_reg.rdata;
            endcase
        end
        // software may only clear done
        if (wrOne && !pwdata[B_DONE]) begin
            s_next.done = 1'b0;
        end
        if (!s_reg.ctlTwo[B_ALT]) begin
            s_next.altB = 1'b0;
        end

        unique case (s_reg.st)
            ST_IDLE: begin
                if (s_reg.ctlOne[B_ON] && (s_reg.ctlOne[B_ASTART]
                        || (wrOne && pwdata[B_SAMPLE]))) begin
                    s_next.st  = ST_SAMPLE;
                    s_next.cnt = 5'h0;
                    if (s_reg.ctlTwo[B_SCAN]) begin
                        // start above every slot so the lowest set bit comes first
                        s_next.slot = next_slot(scanMask, SLOT_NONE);
                    end
                end
            end
            ST_SAMPLE: begin
                if (trigSrc == TRIG_AUTO) begin
                    if (tadTick) begin
                        s_next.cnt = s_reg.cnt + 5'h1;
                        if (s_reg.cnt + 5'h1 >= s_reg.ctlThree[B_SAMT_LO +: 5]) begin
                            toConvert = 1'b1;
                        end
                    end
                end else if (trigSrc == TRIG_SOFT) begin
                    toConvert = wrOne && !pwdata[B_SAMPLE];
                end else begin
                    // other trigger codes: synced rising edge of the trigger pin
                    toConvert = s_reg.trigSync[1] & ~s_reg.trigLast;
                end
                if (toConvert) begin
                    s_next.st   = ST_CONVERT;
                    s_next.cnt  = 5'h0;
                    s_next.done = 1'b0;
                end
            end
            ST_CONVERT: begin
                if (tadTick) begin
                    s_next.cnt = s_reg.cnt + 5'h1;
                    if (s_reg.cnt + 5'h1 >= CONV_TADS) begin
                        convEnd = 1'b1;
                    end
                end
            end
        endcase

        // done is set after any software clear above,
        // so the set wins when both fall in one cycle
        if (convEnd) begin
            s_next.done     = 1'b1;
            s_next.st       = s_reg.ctlOne[B_ASTART] ? ST_SAMPLE : ST_IDLE;
            s_next.cnt      = 5'h0;
            base            = s_reg.ctlTwo[B_SPLIT] ? {s_reg.half, 3'h0} : 4'h0;
            s_next.resValid = 1'b1;
            s_next.resIdx   = base | s_reg.offs;
            s_next.resData  = s_reg.sarSync;
            s_next.altB     = s_reg.ctlTwo[B_ALT] & ~s_reg.altB;
            if (s_reg.ctlTwo[B_SCAN]) begin
                s_next.slot = next_slot(scanMask, s_reg.slot);
            end
            // event count and buffer offset advance once per conversion
            if (s_reg.seqCnt >= s_reg.ctlTwo[B_SEQ_LO +: 4]) begin
                s_next.evt    = 1'b1;
                s_next.seqCnt = 4'h0;
                s_next.offs   = 4'h0;
                if (s_reg.ctlTwo[B_SPLIT]) begin
                    s_next.half = ~s_reg.half;
                end
            end else begin
                s_next.seqCnt = s_reg.seqCnt + 4'h1;
                s_next.offs   = s_reg.ctlTwo[B_SPLIT] ? {1'b0, s_reg.offs[2:0] + 3'h1}
                                                      : s_reg.offs + 4'h1;
            end
        end

        // clearing on abandons a sample or conversion in flight
        if (!s_reg.ctlOne[B_ON]) begin
            s_next.st = ST_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign sampling    = s_reg.st == ST_SAMPLE;
    assign converting  = s_reg.st == ST_CONVERT;
    assign resultValid = s_reg.resValid;
    assign resultIndex = s_reg.resIdx;
    assign resultData  = s_reg.resData;
    assign seqEvent    = s_reg.evt;
endmodule // conversion_clock_divider_sequencer

// ===== dv/conversion_clock_divider_checker.sv
// port assertions of the converter sequencer
`timescale 1ns/1ps
module conversion_clock_divider_checker (
    input wire logic        ref_clk,     // system clock
    input wire logic        rst_n,       // synchronous reset
    input wire logic        psel,        // apb select
    input wire logic        penable,     // apb enable
    input wire logic [7:0]  paddr,       // apb byte address
    input wire logic [31:0] prdata,      // apb read data
    input wire logic        pready,      // apb ready
    input wire logic        pslverr,     // apb error
    input wire logic        sampling,    // tracking
    input wire logic        converting,  // conversion running
    input wire logic        resultValid, // result strobe
    input wire logic        seqEvent     // interrupt event
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_bad_access;
        psel && penable && paddr > 8'h14;
    endsequence
    sequence s_good_access;
        psel && penable && paddr <= 8'h14;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_ready_access: assert property (s_access |-> pready)
        else $error("pready missing in access phase");
    a_err_unmapped: assert property (s_bad_access |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_ok_mapped: assert property (s_good_access |-> !pslverr)
        else $error("mapped access refused");
    a_result_pulse: assert property (resultValid |=> !resultValid)
        else $error("result strobe longer than one cycle");
    a_event_pulse: assert property (seqEvent |=> !seqEvent)
        else $error("event longer than one cycle");
    a_event_result: assert property (seqEvent |-> resultValid)
        else $error("event without completed conversion");
    a_state_excl: assert property (!(sampling && converting))
        else $error("sampling and converting together");
    a_conv_start: assert property ($rose(converting) |-> $past(sampling))
        else $error("conversion not preceded by sampling");
    a_result_src: assert property (resultValid |-> $past(converting) || $past(converting, 2))
        else $error("result without conversion");
endmodule // conversion_clock_divider_checker

bind conversion_clock_divider_sequencer conversion_clock_divider_checker u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sampling(sampling),
    .converting(converting), .resultValid(resultValid), .seqEvent(seqEvent)
);

// ===== dv/tb_top.sv
// self-checking bench of the converter sequencer
`timescale 1ns/1ps
module tb_top
    import conversion_clock_divider_pkg::*;
();
    logic        ref_clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        frcClk;
    logic [9:0]  sarData;
    logic [5:0]  muxPos;
    logic        muxPosLowRef;
    logic        muxNegAn1;
    logic        sampling;
    logic        converting;
    logic        resultValid;
    logic [3:0]  resultIndex;
    logic [9:0]  resultData;
    logic        seqEvent;
    logic [20:0] expQ[$];
    logic [5:0]  muxConv;
    logic [31:0] masks [6];
    logic [31:0] rd;
    logic        err;
    logic [9:0]  softData;
    int          n_fail;
    int          compares;
    int          cyc;
    int          lastRes;
    int          gap;
    int          g0;
    integer      seed;

    conversion_clock_divider_sequencer dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frcClk(frcClk), .trigIn(1'b0), .sarData(sarData),
        .muxPos(muxPos), .muxPosLowRef(muxPosLowRef), .muxNegAn1(muxNegAn1),
        .sampling(sampling), .converting(converting), .resultValid(resultValid),
        .resultIndex(resultIndex), .resultData(resultData), .seqEvent(seqEvent)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            n++;
        end
        if (pready !== 1'b1)
            n_fail++;
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    // wait for every noted result; a stall counts as a mismatch
    task automatic drain();
        int n;
        n = 0;
        while (expQ.size() > 0 && n < 20000) begin
            @(posedge ref_clk);
            n++;
        end
        if (expQ.size() > 0)
            n_fail++;
    endtask

    // one auto-sampled run; expected results noted before start
    task automatic run(input logic [31:0] c2, c3, sel, input int nres,
                       input logic [5:0] m0, m1);
        int k;
        int off;
        int half;
        int nn;
        logic ev;
        logic [9:0] d;
        off = 0;
        half = 0;
        nn = int'(c2[5:2]);
        d = 10'($random(seed));
        sarData <= d;
        apb(1'b1, OFS_CTL_TWO, c2);
        apb(1'b1, OFS_CTL_THREE, c3);
        apb(1'b1, OFS_IN_SEL, sel);
        for (k = 0; k < nres; k++) begin
            ev = (k % (nn + 1)) == nn;
            expQ.push_back({ev, k[0] ? m1 : m0, 4'(c2[1] ? half * 8 + off : off), d});
            off = ev ? 0 : off + 1;
            if (ev && c2[1])
                half ^= 1;
        end
        apb(1'b1, OFS_CTL_ONE, 32'h0000_80E4);
        drain();
        apb(1'b0, OFS_CTL_ONE, 32'h0);
        check("control one", rd, 32'h0000_80E7);
        apb(1'b1, OFS_CTL_ONE, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // free-running fast oscillator, 40 ns period against the 10 ns bus clock
    initial begin
        frcClk = 1'b0;
        forever #20 frcClk = ~frcClk;
    end

    always @(posedge ref_clk) begin
        if (converting === 1'b1)
            muxConv = muxPos;
        if (resultValid === 1'b1) begin
            if (expQ.size() == 0)
                check("extra result", 32'h1, 32'h0);
            else
                check("result", 32'({seqEvent, muxConv, resultIndex, resultData}), 32'(expQ.pop_front()));
            gap = cyc - lastRes;
            lastRes = cyc;
        end
        cyc++;
    end

    initial begin
        repeat (50000) @(posedge ref_clk);
        n_fail++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h9d73731b;
        masks = '{MASK_CTL_ONE, MASK_CTL_TWO, MASK_CTL_THREE, MASK_IN_SEL, MASK_SCAN_LO,
                  MASK_SCAN_HI};
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sarData = 10'h000;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            check("reset read", rd, 32'h0);
            check("refusal", 32'(err), 32'(i == 6));
        end
        for (int i = 1; i < 6; i++) begin
            apb(1'b1, 8'(i * 4), 32'hFFFF_FFFF);
            apb(1'b0, 8'(i * 4), 32'h0);
            check("writable bits", rd, masks[i]);
            apb(1'b1, 8'(i * 4), 32'h0);
        end
        apb(1'b1, OFS_IN_SEL, 32'h0085_0000);
        check("mux select", 32'({muxPosLowRef, muxNegAn1, muxPos}), 32'h0000_0045);
        apb(1'b1, OFS_CTL_TWO, 32'h0000_1000);
        check("mux offset cal", 32'({muxPosLowRef, muxNegAn1}), 32'h2);
        apb(1'b1, OFS_CTL_TWO, 32'h0);
        apb(1'b1, OFS_IN_SEL, 32'h0033_0000);
        check("absent input", 32'(muxPosLowRef), 32'h1);
        run(32'h0000_0006, 32'h0000_0400, 32'h0005_0000, 4, 6'h05, 6'h05);
        g0 = gap;
        run(32'h0000_0001, 32'h0000_0402, 32'h0905_0000, 2, 6'h05, 6'h09);
        check("divider gap", 32'(gap - g0), 32'd64);
        apb(1'b1, OFS_SCAN_LO, 32'h0000_0008);
        apb(1'b1, OFS_SCAN_HI, 32'h0004_0000);
        run(32'h0000_040C, 32'h0000_0800, 32'h0, 4, 6'h03, 6'h32);
        check("sample time gap", 32'(gap - g0), 32'd8);
        run(32'h0, 32'h0000_84FF, 32'h0005_0000, 2, 6'h05, 6'h05);
        check("rc clock gap", 32'(gap < 200), 32'h1);
        // software trigger: sample time ignored, split half flips
        softData = 10'($random(seed));
        sarData <= softData;
        apb(1'b1, OFS_CTL_TWO, 32'h0000_0002);
        apb(1'b1, OFS_CTL_THREE, 32'h0000_0100);
        expQ.push_back({1'b1, 6'h05, 4'h0, softData});
        apb(1'b1, OFS_CTL_ONE, 32'h0000_8000);
        apb(1'b1, OFS_CTL_ONE, 32'h0000_8002);
        repeat (20) @(posedge ref_clk);
        apb(1'b0, OFS_CTL_ONE, 32'h0);
        check("soft sampling", rd, 32'h0000_8002);
        apb(1'b1, OFS_CTL_ONE, 32'h0000_8000);
        drain();
        apb(1'b0, OFS_CTL_TWO, 32'h0);
        check("half status", rd, 32'h0000_0082);
        apb(1'b0, OFS_CTL_ONE, 32'h0);
        check("done status", rd, 32'h0000_8001);
        apb(1'b1, OFS_CTL_ONE, 32'h0);
        end_sim();
    end
endmodule // tb_top
